// file: bench/testbench.sv
// Testbench for the teletype serial interface
`timescale 1ns/1ps
`include "tsi_consts.vh"
module testbench;
  localparam BC = 40;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000, rd, prdata;
  logic pready, er, pslverr, rx, tx, irq, rrun;
  logic [7:0] got;
  int cnt, n, mismatches = 0, compares = 0;
  tsi_core #(.BIT_CYC(BC)) uut (.core_clk_i(clk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .serial_rx_i(rx), .serial_tx_o(tx),
    .std_irq_o(irq), .reader_run_o(rrun));
  tsi_tty #(.BC(BC)) tty (.clk_i(clk), .tx_i(tx), .rx_o(rx),
    .got_o(got), .cnt_o(cnt));
  // Free-running core clock
  always #5 clk = ~clk;
  task stop_test;
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (int i = 0; i <= 50; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
      if (i == 50) begin
        mismatches++;
        stop_test;
      end
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Issue an instruction, then fetch its skip result
  task ex(input logic [3:0] c, input logic [9:0] f);
    apb(1'b1, `TSI_CMD_ADDR, {16'h0000, c, 2'b00, f});
    apb(1'b0, `TSI_RES_ADDR, 32'h0000_0000);
  endtask
  task wacc(input logic [15:0] v);
    apb(1'b1, `TSI_ACC_ADDR, {16'h0000, v});
  endtask
  // Repeat a skip test until it skips, within a bound
  task poll(input logic [9:0] f);
    for (int i = 0; i <= 400; i++) begin
      ex(`TSI_CLS_SKS, f);
      if (rd[0] === 1'b1) break;
      if (i == 400) begin
        mismatches++;
        stop_test;
      end
    end
  endtask
  task t_reset;
    apb(1'b0, `TSI_STAT_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_0040);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0001);
    wacc(16'h1234);
    ex(`TSI_CLS_INA, `TSI_FN_ASCII);
    chk(rd, 32'h0000_0000);
    ex(`TSI_CLS_SKS, `TSI_FN_READY);
    chk(rd, 32'h0000_0000);
    ex(`TSI_CLS_OTA, `TSI_FN_ASCII);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `TSI_ACC_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_1234);
  endtask
  logic [7:0] rc [4] = '{8'hA5, 8'hC7, 8'h5A, 8'hFF};
  logic [9:0] rf [4] = '{`TSI_FN_ASCII, `TSI_FN_BINARY,
                         `TSI_FN_CLR_ASCII, `TSI_FN_CLR_BINARY};
  logic [15:0] ra [4] = '{16'hFF00, 16'h1230, 16'hFFFF, 16'hFFC0};
  logic [15:0] re [4] = '{16'hFFA5, 16'h1237, 16'h005A, 16'h003F};
  task t_rx;
    for (int k = 0; k < 4; k++) begin
      wacc(ra[k]);
      fork
        tty.send(rc[k]);
        begin
          repeat (BC * 3) @(posedge clk);
          ex(`TSI_CLS_SKS, `TSI_FN_NOT_BUSY);
          chk(rd, 32'h0000_0000);
        end
      join
      poll(`TSI_FN_READY);
      ex(`TSI_CLS_INA, rf[k]);
      chk(rd, 32'h0000_0001);
      apb(1'b0, `TSI_ACC_ADDR, 32'h0000_0000);
      chk(rd, {16'h0000, re[k]});
    end
  endtask
  logic [7:0] sc [5] = '{8'h93, 8'h41, 8'h42, 8'h13, 8'h20};
  task t_stop;
    for (int k = 0; k < 5; k++) begin
      tty.send(sc[k]);
      ex(`TSI_CLS_SKS, `TSI_FN_NO_STOP);
      chk(rd[0], 32'(k[0] ^ k[1] ^ k[2]));
      if (k < 3) chk(rrun, 32'(k < 2));
      if (k == 2) ex(`TSI_CLS_CTL, `TSI_FN_IN_MODE);
    end
  endtask
  task t_irq;
    wacc(16'h0800);
    ex(`TSI_CLS_SMK, `TSI_FN_MASK);
    ex(`TSI_CLS_SKS, `TSI_FN_NOT_INT);
    chk({rd[0], irq}, 32'h0000_0001);
    wacc(16'hF7FF);
    ex(`TSI_CLS_SMK, `TSI_FN_MASK);
    ex(`TSI_CLS_SKS, `TSI_FN_NOT_INT);
    chk({rd[0], irq}, 32'h0000_0002);
  endtask
  logic [15:0] ta [3] = '{16'h00C3, 16'h0065, 16'h0085};
  logic [9:0] tf [3] = '{`TSI_FN_ASCII, `TSI_FN_BINARY, `TSI_FN_BINARY};
  logic [7:0] te [3] = '{8'hC3, 8'h25, 8'hC5};
  task t_tx;
    poll(`TSI_FN_NOT_BUSY);
    ex(`TSI_CLS_CTL, `TSI_FN_OUT_MODE);
    for (int k = 0; k < 3; k++) begin
      poll(`TSI_FN_READY);
      wacc(ta[k]);
      n = cnt;
      ex(`TSI_CLS_OTA, tf[k]);
      chk(rd, 32'h0000_0001);
      ex(`TSI_CLS_OTA, tf[k]);
      chk(rd, 32'h0000_0000);
      ex(`TSI_CLS_SKS, `TSI_FN_NOT_BUSY);
      chk(rd, 32'h0000_0000);
      poll(`TSI_FN_NOT_BUSY);
      chk({got, 24'(cnt - n)}, {te[k], 24'h00_0001});
    end
    ex(`TSI_CLS_CTL, `TSI_FN_IN_MODE);
    tty.send(8'h33);
    poll(`TSI_FN_READY);
    ex(`TSI_CLS_INA, `TSI_FN_CLR_ASCII);
    apb(1'b0, `TSI_ACC_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_0033);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_rx;
    t_stop;
    t_irq;
    t_tx;
    stop_test;
  end
endmodule

// file: bench/tsi_core_sva.sv
// Port checker for the teletype serial interface
`timescale 1ns/1ps
`include "tsi_consts.vh"
module tsi_core_sva #(
  parameter BIT_CYC = `TSI_BIT_CYC
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire serial_tx_o,
  input wire std_irq_o,
  input wire reader_run_o
);
  logic [15:0] acc_q;
  logic mask_q;
  wire acs_w = psel_i && penable_i;
  wire wr_w = acs_w && pwrite_i;
  // Shadow of accumulator writes and the mask they set
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= 16'h0000;
      mask_q <= 1'b0;
    end else if (wr_w && paddr_i == `TSI_ACC_ADDR) begin
      acc_q <= pwdata_i[15:0];
    end else if (wr_w && paddr_i == `TSI_CMD_ADDR &&
                 pwdata_i[15:12] == `TSI_CLS_SMK &&
                 pwdata_i[9:0] == `TSI_FN_MASK) begin
      mask_q <= acc_q[`TSI_MASK_BIT];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Read setup followed by its access cycle
  sequence s_rd(a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a ##1 acs_w;
  endsequence
  property p_rdy;
    acs_w |-> pready_o;
  endproperty
  property p_map;
    acs_w && paddr_i <= `TSI_CFG_ADDR && paddr_i[1:0] == 2'b00
      |-> !pslverr_o;
  endproperty
  property p_unm;
    acs_w && paddr_i > `TSI_CFG_ADDR |-> pslverr_o;
  endproperty
  property p_unm_rd;
    acs_w && !pwrite_i && pslverr_o |-> prdata_o == 32'h0000_0000;
  endproperty
  property p_irq;
    std_irq_o |-> mask_q;
  endproperty
  property p_stat;
    s_rd(`TSI_STAT_ADDR) |-> prdata_o[3] == mask_q &&
      prdata_o[4] == $past(std_irq_o) && prdata_o[6] == $past(reader_run_o);
  endproperty
  property p_res;
    s_rd(`TSI_RES_ADDR) |-> prdata_o[31:1] == 31'h0000_0000;
  endproperty
  property p_start;
    $fell(serial_tx_o) |-> !serial_tx_o [*8];
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("pready low in access");
  a_map: assert property (p_map)
    else $error("error on mapped address");
  a_unm: assert property (p_unm)
    else $error("no error on unmapped address");
  a_unm_rd: assert property (p_unm_rd)
    else $error("unmapped read not zero");
  a_irq: assert property (p_irq)
    else $error("interrupt with mask clear");
  a_stat: assert property (p_stat)
    else $error("status bits wrong");
  a_res: assert property (p_res)
    else $error("result upper bits set");
  a_start: assert property (p_start)
    else $error("start bit too short");
endmodule
bind tsi_core tsi_core_sva #(.BIT_CYC(BIT_CYC)) u_sva (.core_clk_i,
  .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .serial_tx_o, .std_irq_o,
  .reader_run_o);

// file: bench/tsi_tty.sv
// Terminal model: printer decoder and keyboard or reader sender
`timescale 1ns/1ps
module tsi_tty #(
  parameter BC = 40
) (
  input wire clk_i,
  input wire tx_i,
  output logic rx_o,
  output logic [7:0] got_o,
  output int cnt_o
);
  initial begin
    rx_o = 1'b1;
    cnt_o = 0;
  end
  // Printer: sample mid-bit, eight data bits LSB first
  always begin
    @(negedge tx_i);
    repeat (BC + BC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      got_o[i] = tx_i;
      repeat (BC) @(posedge clk_i);
    end
    cnt_o++;
  end
  // Keyboard: start bit, data LSB first, one stop bit, idle high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      rx_o <= f[k];
      repeat (BC) @(posedge clk_i);
    end
  endtask
endmodule

// file: pkg/tsi_consts.vh
// Constants for the teletype serial interface
`ifndef TSI_CONSTS_VH
`define TSI_CONSTS_VH
// Register byte addresses on APB
`define TSI_CMD_ADDR 12'h000
`define TSI_ACC_ADDR 12'h004
`define TSI_STAT_ADDR 12'h008
`define TSI_RES_ADDR 12'h00C
`define TSI_CFG_ADDR 12'h010
// Instruction classes written to the command register bits 15:12
`define TSI_CLS_CTL 4'h1
`define TSI_CLS_SKS 4'h2
`define TSI_CLS_INA 4'h3
`define TSI_CLS_OTA 4'h4
`define TSI_CLS_SMK 4'h5
// Function codes in command bits 9:0 (hex values)
`define TSI_FN_IN_MODE 10'h004
`define TSI_FN_OUT_MODE 10'h044
`define TSI_FN_READY 10'h004
`define TSI_FN_NOT_BUSY 10'h044
`define TSI_FN_NOT_INT 10'h104
`define TSI_FN_NO_STOP 10'h144
`define TSI_FN_ASCII 10'h004
`define TSI_FN_BINARY 10'h084
`define TSI_FN_CLR_ASCII 10'h204
`define TSI_FN_CLR_BINARY 10'h284
`define TSI_FN_MASK 10'h010
// Stop codes, octal 223 and 023
`define TSI_STOP_HI 8'h93
`define TSI_STOP_LO 8'h13
// Mask bit position in the accumulator
`define TSI_MASK_BIT 11
// Serial timing
`define TSI_CLK_HZ 100000000
`define TSI_BAUD 110
`define TSI_BIT_CYC (`TSI_CLK_HZ / `TSI_BAUD)
`endif

// file: rtl/tsi_bit_timer.v
// Bit-period timer with restart input and tick output
`timescale 1ns/1ps
module tsi_bit_timer #(
  parameter CYC = 909090,
  parameter W = 20
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire restart_i,
  input wire [W-1:0] load_i,
  output wire tick_o
);
  reg [W-1:0] cnt_q;
  // Counts down, reloads on restart or on reaching zero
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= {W{1'b0}};
    end else if (restart_i) begin
      cnt_q <= load_i;
    end else if (cnt_q == {W{1'b0}}) begin
      cnt_q <= CYC[W-1:0] - {{(W-1){1'b0}}, 1'b1};
    end else begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign tick_o = (cnt_q == {W{1'b0}}) && !restart_i;
endmodule

// file: rtl/tsi_core.v
// Teletype serial interface: instruction decode, UART, APB slave
`timescale 1ns/1ps
`include "tsi_consts.vh"
module tsi_core #(
  parameter BIT_CYC = `TSI_BIT_CYC,
  parameter TW = 20
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire serial_rx_i,
  output reg serial_tx_o,
  output wire std_irq_o,
  output wire reader_run_o
);
  // Shared state codes for receive and transmit
  localparam ST_IDLE = 2'd0;
  localparam ST_SHIFT = 2'd1;
  // 1 start, 8 data, 2 stop bits on the line
  localparam [3:0] NBITS = 4'd11;
  localparam integer HALF_I = BIT_CYC / 2;
  localparam integer FULL_I = BIT_CYC - 1;
  localparam [TW-1:0] HALF = HALF_I[TW-1:0];
  localparam [TW-1:0] FULL = FULL_I[TW-1:0];

  reg out_mode_q;
  reg mask_q;
  reg [15:0] acc_q;
  reg skip_q;
  reg [7:0] rx_buf_q;
  reg rx_rdy_q;
  reg stop_q;
  reg [1:0] rx_st_q;
  reg [3:0] rx_cnt_q;
  reg [7:0] rx_sh_q;
  reg [1:0] tx_st_q;
  reg [3:0] tx_cnt_q;
  reg [10:0] tx_sh_q;
  reg tx_rdy_q;
  reg stop_run_q;
  reg [1:0] tail_q;

  // APB access decode, one access cycle per transfer
  wire wr = psel_i && penable_i && pwrite_i;
  // Reads have no side effects, so only writes are decoded here
  wire cmd_wr = wr && (paddr_i == `TSI_CMD_ADDR);
  wire acc_wr = wr && (paddr_i == `TSI_ACC_ADDR);
  wire [3:0] cls = pwdata_i[15:12];
  wire [9:0] fn = pwdata_i[9:0];
  wire known = (paddr_i == `TSI_CMD_ADDR) || (paddr_i == `TSI_ACC_ADDR) ||
               (paddr_i == `TSI_STAT_ADDR) || (paddr_i == `TSI_RES_ADDR) ||
               (paddr_i == `TSI_CFG_ADDR);
  // Status terms shared by the skip tests and the status read
  wire busy = (tx_st_q != ST_IDLE) || (rx_st_q != ST_IDLE);
  wire ready = out_mode_q ? tx_rdy_q : rx_rdy_q;
  wire irq = ready && mask_q;
  // Instruction strobes; refused instructions fall through as no-ops
  wire do_ctl = cmd_wr && (cls == `TSI_CLS_CTL);
  wire do_sks = cmd_wr && (cls == `TSI_CLS_SKS);
  wire do_ina = cmd_wr && (cls == `TSI_CLS_INA) && !out_mode_q &&
                rx_rdy_q && ((fn == `TSI_FN_ASCII) ||
                (fn == `TSI_FN_BINARY) || (fn == `TSI_FN_CLR_ASCII) ||
                (fn == `TSI_FN_CLR_BINARY));
  wire do_ota = cmd_wr && (cls == `TSI_CLS_OTA) && out_mode_q &&
                tx_rdy_q && ((fn == `TSI_FN_ASCII) ||
                (fn == `TSI_FN_BINARY));
  wire do_smk = cmd_wr && (cls == `TSI_CLS_SMK) && (fn == `TSI_FN_MASK);
  wire rx_tick;
  wire tx_tick;
  // A low line while idle in input mode opens a receive frame
  wire rx_start = !out_mode_q && (rx_st_q == ST_IDLE) && !serial_rx_i;
  wire tx_start = do_ota;
  wire [7:0] tx_char;
  wire [7:0] rx_data;
  wire rx_done;

  // Zero wait states; unmapped accesses flag an error
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !known;
  assign std_irq_o = irq;
  assign reader_run_o = !stop_run_q;

  // Receive and transmit bit timers
  tsi_bit_timer #(.CYC(BIT_CYC), .W(TW)) u_rx_tmr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .restart_i(rx_start),
    .load_i(HALF),
    .tick_o(rx_tick)
  );
  tsi_bit_timer #(.CYC(BIT_CYC), .W(TW)) u_tx_tmr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .restart_i(tx_start),
    .load_i(FULL),
    .tick_o(tx_tick)
  );

  // Binary output forces channel 7 to the inverse of channel 6
  assign tx_char = (fn == `TSI_FN_BINARY) ?
                   {acc_q[7], ~acc_q[5], acc_q[5:0]} : acc_q[7:0];
  assign rx_data = {serial_rx_i, rx_sh_q[7:1]};
  assign rx_done = (rx_st_q == ST_SHIFT) && rx_tick &&
                   (rx_cnt_q == 4'd9);

  // Direction and mask
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_mode_q <= 1'b0;
      mask_q <= 1'b0;
    end else begin
      if (do_ctl && (fn == `TSI_FN_IN_MODE)) begin
        out_mode_q <= 1'b0;
      end else if (do_ctl && (fn == `TSI_FN_OUT_MODE)) begin
        out_mode_q <= 1'b1;
      end
      if (do_smk) begin
        mask_q <= acc_q[`TSI_MASK_BIT];
      end
    end
  end

  // Accumulator and skip result
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= 16'h0000;
      skip_q <= 1'b0;
    end else begin
      if (acc_wr) begin
        acc_q <= pwdata_i[15:0];
      end else if (do_ina) begin
        case (fn)
          `TSI_FN_ASCII: acc_q <= acc_q | {8'h00, rx_buf_q};
          `TSI_FN_BINARY: acc_q <= acc_q | {10'h000, rx_buf_q[5:0]};
          `TSI_FN_CLR_ASCII: acc_q <= {8'h00, rx_buf_q};
          `TSI_FN_CLR_BINARY: acc_q <= {10'h000, rx_buf_q[5:0]};
          default: acc_q <= acc_q;
        endcase
      end
      if (do_sks) begin
        case (fn)
          `TSI_FN_READY: skip_q <= ready;
          `TSI_FN_NOT_BUSY: skip_q <= !busy;
          `TSI_FN_NOT_INT: skip_q <= !irq;
          `TSI_FN_NO_STOP: skip_q <= !stop_q;
          default: skip_q <= 1'b0;
        endcase
      end else if (cmd_wr && (cls == `TSI_CLS_INA)) begin
        skip_q <= do_ina;
      end else if (cmd_wr && (cls == `TSI_CLS_OTA)) begin
        skip_q <= do_ota;
      end else if (cmd_wr) begin
        skip_q <= 1'b0;
      end
    end
  end

  // Serial receiver, busy from start bit to ready
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st_q <= ST_IDLE;
      rx_cnt_q <= 4'd0;
      rx_sh_q <= 8'h00;
      rx_buf_q <= 8'h00;
      rx_rdy_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      case (rx_st_q)
        ST_IDLE: begin
          if (rx_start) begin
            rx_st_q <= ST_SHIFT;
            rx_cnt_q <= 4'd0;
          end
        end
        ST_SHIFT: begin
          if (rx_tick) begin
            rx_cnt_q <= rx_cnt_q + 4'd1;
            if (rx_cnt_q == 4'd0 && serial_rx_i) begin
              rx_st_q <= ST_IDLE;
            end else if (rx_cnt_q >= 4'd1 && rx_cnt_q <= 4'd8) begin
              rx_sh_q <= rx_data;
            end else if (rx_cnt_q == 4'd9) begin
              rx_st_q <= ST_IDLE;
            end
          end
        end
        default: rx_st_q <= ST_IDLE;
      endcase
      // Buffer keeps accepting after a stop code
      if (rx_done) begin
        rx_buf_q <= rx_sh_q;
        stop_q <= (rx_sh_q == `TSI_STOP_HI) ||
                  (rx_sh_q == `TSI_STOP_LO);
      end
      if (rx_done) begin
        rx_rdy_q <= 1'b1;
      end else if (do_ina) begin
        rx_rdy_q <= 1'b0;
      end
      if (out_mode_q) begin
        stop_q <= 1'b0;
      end
    end
  end

  // Any control pulse re-arms the reader so the host can restart it
  // Reader run request: stop after code plus two characters
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_run_q <= 1'b0;
      tail_q <= 2'd0;
    end else if (do_ctl) begin
      stop_run_q <= 1'b0;
      tail_q <= 2'd0;
    end else if (rx_done) begin
      if ((rx_sh_q == `TSI_STOP_HI) || (rx_sh_q == `TSI_STOP_LO)) begin
        tail_q <= 2'd2;
      end else if (tail_q != 2'd0) begin
        tail_q <= tail_q - 2'd1;
        if (tail_q == 2'd1) begin
          stop_run_q <= 1'b1;
        end
      end
    end
  end

  // Serial transmitter, busy from load to end of last stop bit
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st_q <= ST_IDLE;
      tx_cnt_q <= 4'd0;
      tx_sh_q <= 11'h7FF;
      tx_rdy_q <= 1'b1;
      serial_tx_o <= 1'b1;
    end else begin
      case (tx_st_q)
        ST_IDLE: begin
          serial_tx_o <= 1'b1;
          if (tx_start) begin
            tx_sh_q <= {2'b11, tx_char, 1'b0};
            tx_cnt_q <= 4'd0;
            tx_st_q <= ST_SHIFT;
            tx_rdy_q <= 1'b0;
          end
        end
        ST_SHIFT: begin
          serial_tx_o <= tx_sh_q[0];
          if (tx_tick) begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q <= tx_cnt_q + 4'd1;
            if (tx_cnt_q == NBITS - 4'd1) begin
              tx_st_q <= ST_IDLE;
              tx_rdy_q <= 1'b1;
            end
          end
        end
        default: tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // APB read data, registered in the setup cycle
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        `TSI_ACC_ADDR: prdata_o <= {16'h0000, acc_q};
        `TSI_STAT_ADDR: prdata_o <= {25'h000_0000, reader_run_o, stop_q,
                                     irq, mask_q, busy, ready, out_mode_q};
        `TSI_RES_ADDR: prdata_o <= {31'h0000_0000, skip_q};
        `TSI_CFG_ADDR: prdata_o <= {24'h00_0000, rx_buf_q};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule
